/* File: hdl/sms_spi.sv */
`timescale 1ns/100ps
`default_nettype none
module sms_spi (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       sck_in,
   input  wire logic       mosi_in,
   input  wire logic       miso_in,
   input  wire logic       ss_in,
   input  wire logic       interface_enable,
   input  wire logic       transfer_irq_enable,
   input  wire logic       bit_order_select,
   input  wire logic       clock_idle_level,
   input  wire logic       clock_sample_phase,
   input  wire logic       rate_select_hi,
   input  wire logic       rate_select_lo,
   input  wire logic       double_speed,
   input  wire logic       ctrl_wr,
   input  wire logic       ctrl_master_select,
   input  wire logic       mosi_dir,
   input  wire logic       miso_dir,
   input  wire logic       sck_dir,
   input  wire logic       ss_dir,
   input  wire logic       ss_drive_level,
   input  wire logic       data_wr,
   input  wire logic [7:0] data_wdata,
   input  wire logic       data_rd,
   input  wire logic       status_rd,
   input  wire logic       irq_ack,
   output var  logic [7:0] rx_data,
   output var  logic       master_select,
   output var  logic       transfer_complete_flag,
   output var  logic       write_collision_flag,
   output var  logic       irq,
   output var  logic       mosi_out,
   output var  logic       mosi_oe,
   output var  logic       miso_out,
   output var  logic       miso_oe,
   output var  logic       sck_out,
   output var  logic       sck_oe,
   output var  logic       ss_out,
   output var  logic       ss_oe
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [6:0] half_period(input logic dbl, input logic hi,
                                              input logic lo);
      logic [6:0] h;
      h = sms_pkg::SMS_HALF_N0;
      unique case ({dbl, hi, lo})
         3'h0: h = sms_pkg::SMS_HALF_N0;
         3'h1: h = sms_pkg::SMS_HALF_N1;
         3'h2: h = sms_pkg::SMS_HALF_N2;
         3'h3: h = sms_pkg::SMS_HALF_N3;
         3'h4: h = sms_pkg::SMS_HALF_D0;
         3'h5: h = sms_pkg::SMS_HALF_D1;
         3'h6: h = sms_pkg::SMS_HALF_D2;
         3'h7: h = sms_pkg::SMS_HALF_D3;
      endcase
      return h;
   endfunction : half_period

   function automatic logic [7:0] shift_byte(input logic [7:0] sh, input logic din,
                                             input logic lsb_first);
      return lsb_first ? {din, sh[7:1]} : {sh[6:0], din};
   endfunction : shift_byte

   function automatic logic out_bit(input logic [7:0] sh, input logic lsb_first);
      return lsb_first ? sh[0] : sh[7];
   endfunction : out_bit

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: capture MOSI on both SCK edges. The core domain reads these
   // only after the synchronised SCK shows the edge, by when they are stable.
   logic bit_pos_reg;
   logic bit_neg_reg;

   always_ff @(posedge sck_in) begin
      bit_pos_reg <= mosi_in;
   end

   always_ff @(negedge sck_in) begin
      bit_neg_reg <= mosi_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic sck_s1_reg;
   logic sck_s2_reg;
   logic sck_s3_reg;
   logic ss_s1_reg;
   logic ss_s2_reg;
   logic miso_s1_reg;
   logic miso_s2_reg;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sck_s1_reg  <= 1'b0;
         sck_s2_reg  <= 1'b0;
         sck_s3_reg  <= 1'b0;
         ss_s1_reg   <= 1'b1;
         ss_s2_reg   <= 1'b1;
         miso_s1_reg <= 1'b0;
         miso_s2_reg <= 1'b0;
      end else begin
         sck_s1_reg  <= sck_in;
         sck_s2_reg  <= sck_s1_reg;
         sck_s3_reg  <= sck_s2_reg;
         ss_s1_reg   <= ss_in;
         ss_s2_reg   <= ss_s1_reg;
         miso_s1_reg <= miso_in;
         miso_s2_reg <= miso_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sms_pkg::sms_state_t state_reg;
   logic [6:0] div_cnt_reg;
   logic [3:0] edge_cnt_reg;
   logic [7:0] sh_reg;
   logic [7:0] sh_next;
   logic       latch_reg;
   logic       master_reg;
   logic       sck_gen_reg;
   logic [6:0] half;
   logic       master_on;
   logic       slave_sel;
   logic       busy;
   logic       link_edge;
   logic       link_rising;
   logic       sample_bit;
   logic       is_sample;
   logic       byte_done;
   logic       mode_fault;
   logic       wr_ok;
   logic       wr_bad;
   logic       data_access;
   logic       shift_edge;
   logic       m_sample;
   logic       m_end;
   logic       m_done;
   logic       slave_done;
   logic [7:0] mrx_reg;
   logic [7:0] mrx_next;
   logic [sms_pkg::SMS_MISO_LAT-1:0] smp_dly_reg;
   logic [sms_pkg::SMS_MISO_LAT-1:0] end_dly_reg;

   assign half        = half_period(double_speed, rate_select_hi, rate_select_lo);
   assign master_on   = interface_enable & master_reg;
   assign slave_sel   = interface_enable & ~master_reg & ~ss_s2_reg;
   // The master's MISO tail counts as busy so a write cannot overtake rx_data
   assign busy        = (state_reg == sms_pkg::SMS_RUN) |
                        (smp_dly_reg != '0) | (end_dly_reg != '0) |
                        (slave_sel & (edge_cnt_reg != sms_pkg::SMS_EDGE_ZERO));
   assign wr_ok       = data_wr & ~busy;
   assign wr_bad      = data_wr & busy;
   assign data_access = data_wr | data_rd;
   // Select pin used as input and pulled low while master: another master won
   assign mode_fault  = master_on & ~ss_dir & ~ss_s2_reg;

   always_comb begin
      link_edge   = 1'b0;
      link_rising = 1'b0;
      sample_bit  = 1'b0;
      if (state_reg == sms_pkg::SMS_RUN) begin
         link_edge   = (div_cnt_reg == (half - sms_pkg::SMS_HALF_ONE));
         link_rising = ~sck_gen_reg;
         sample_bit  = miso_s2_reg;
      end else if (slave_sel) begin
         link_edge   = sck_s2_reg ^ sck_s3_reg;
         link_rising = sck_s2_reg;
         sample_bit  = sck_s2_reg ? bit_pos_reg : bit_neg_reg;
      end
   end

   // Leading edge leaves the idle level; phase zero samples on it
   assign is_sample = (link_rising ^ clock_idle_level) ^ clock_sample_phase;
   assign byte_done = link_edge & (edge_cnt_reg == sms_pkg::SMS_LAST_EDGE) &
                      ~mode_fault;
   assign m_sample   = (state_reg == sms_pkg::SMS_RUN) & link_edge & is_sample & ~mode_fault;
   assign m_end      = (state_reg == sms_pkg::SMS_RUN) & byte_done;
   assign slave_done = (state_reg == sms_pkg::SMS_IDLE) & byte_done;
   assign m_done     = end_dly_reg[sms_pkg::SMS_MISO_LAT-1];
   assign mrx_next   = smp_dly_reg[sms_pkg::SMS_MISO_LAT-1] ?
                       shift_byte(mrx_reg, miso_s2_reg, bit_order_select) : mrx_reg;
   // Master phase one moves MOSI on leading edges; the first bit already stands
   assign shift_edge = ((state_reg == sms_pkg::SMS_RUN) & clock_sample_phase) ?
                       (~edge_cnt_reg[0] & (edge_cnt_reg != sms_pkg::SMS_EDGE_ZERO)) :
                       edge_cnt_reg[0];

   always_comb begin
      sh_next = sh_reg;
      if (wr_ok) begin
         sh_next = data_wdata;
      end else if (link_edge & shift_edge) begin
         // Slave phase one shifts on the sampling edge itself, phase zero later
         sh_next = shift_byte(sh_reg, clock_sample_phase ? sample_bit : latch_reg,
                              bit_order_select);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Master sequencer and clock generator
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg   <= sms_pkg::SMS_IDLE;
         div_cnt_reg <= '0;
         sck_gen_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            sms_pkg::SMS_IDLE: begin
               sck_gen_reg <= clock_idle_level;
               div_cnt_reg <= '0;
               if (wr_ok & master_on & ~mode_fault) begin
                  state_reg <= sms_pkg::SMS_RUN;
               end
            end
            sms_pkg::SMS_RUN: begin
               if (mode_fault | ~master_on) begin
                  state_reg <= sms_pkg::SMS_IDLE;
               end else if (link_edge) begin
                  div_cnt_reg <= '0;
                  sck_gen_reg <= ~sck_gen_reg;
                  if (byte_done) begin
                     state_reg <= sms_pkg::SMS_IDLE;
                  end
               end else begin
                  div_cnt_reg <= div_cnt_reg + sms_pkg::SMS_HALF_ONE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared shifter, edge counter and sample latch
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sh_reg       <= sms_pkg::SMS_BYTE_ZERO;
         edge_cnt_reg <= sms_pkg::SMS_EDGE_ZERO;
         latch_reg    <= 1'b0;
      end else begin
         sh_reg <= sh_next;
         if (wr_ok | (~master_reg & ss_s2_reg)) begin
            edge_cnt_reg <= sms_pkg::SMS_EDGE_ZERO;
         end else if (link_edge) begin
            edge_cnt_reg <= edge_cnt_reg + sms_pkg::SMS_EDGE_ONE;
         end
         if (link_edge & is_sample) begin
            latch_reg <= sample_bit;
         end
      end
   end

   // MISO lands in miso_s2 three edges after the SCK decision (output register
   // plus two sync flops), so master samples and the byte end ride a delay line
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         smp_dly_reg <= '0;
         end_dly_reg <= '0;
         mrx_reg     <= sms_pkg::SMS_BYTE_ZERO;
      end else begin
         mrx_reg <= mrx_next;
         if (mode_fault) begin
            smp_dly_reg <= '0;
            end_dly_reg <= '0;
         end else begin
            smp_dly_reg <= {smp_dly_reg[sms_pkg::SMS_MISO_LAT-2:0], m_sample};
            end_dly_reg <= {end_dly_reg[sms_pkg::SMS_MISO_LAT-2:0], m_end};
         end
      end
   end

   // Receive buffer only changes on a whole byte, so overrun simply overwrites
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rx_data <= sms_pkg::SMS_BYTE_ZERO;
      end else if (slave_done) begin
         rx_data <= sh_next;
      end else if (m_done) begin
         rx_data <= mrx_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Master select bit and status flags; a flag set beats a clear, a mode fault beats ctrl_wr
   logic tc_armed_reg;
   logic wc_armed_reg;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         master_reg <= 1'b0;
      end else if (mode_fault) begin
         master_reg <= 1'b0;
      end else if (ctrl_wr) begin
         master_reg <= ctrl_master_select;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         transfer_complete_flag <= 1'b0;
         tc_armed_reg           <= 1'b0;
      end else begin
         if (slave_done | m_done | mode_fault) begin
            transfer_complete_flag <= 1'b1;
         end else if ((tc_armed_reg & data_access) | irq_ack) begin
            transfer_complete_flag <= 1'b0;
         end
         if (data_access) begin
            tc_armed_reg <= 1'b0;
         end else if (status_rd & transfer_complete_flag) begin
            tc_armed_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         write_collision_flag <= 1'b0;
         wc_armed_reg         <= 1'b0;
      end else begin
         if (wr_bad) begin
            write_collision_flag <= 1'b1;
         end else if (wc_armed_reg & data_access) begin
            write_collision_flag <= 1'b0;
         end
         if (data_access) begin
            wc_armed_reg <= 1'b0;
         end else if (status_rd & write_collision_flag) begin
            wc_armed_reg <= 1'b1;
         end
      end
   end

   // Level request, registered from the flag and its enable
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= transfer_complete_flag & transfer_irq_enable;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         master_select <= 1'b0;
      end else begin
         master_select <= master_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers. MOSI follows the shifter register so it moves with the SCK
   // setup edge, never in the step of a sampling edge; MISO takes the next
   // value because the slave already sees SCK two cycles late.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mosi_out <= 1'b0;
         mosi_oe  <= 1'b0;
         miso_out <= 1'b0;
         miso_oe  <= 1'b0;
         sck_out  <= 1'b0;
         sck_oe   <= 1'b0;
         ss_out   <= 1'b1;
         ss_oe    <= 1'b0;
      end else begin
         mosi_out <= out_bit(sh_reg, bit_order_select);
         miso_out <= out_bit(sh_next, bit_order_select);
         sck_out  <= sck_gen_reg;
         ss_out   <= ss_drive_level;
         mosi_oe  <= master_on & mosi_dir & ~mode_fault;
         sck_oe   <= master_on & sck_dir & ~mode_fault;
         ss_oe    <= master_on & ss_dir;
         miso_oe  <= slave_sel & miso_dir;
      end
   end

endmodule : sms_spi
`default_nettype wire

/* File: hdl/sms_pkg.sv */
package sms_pkg;

   localparam int SMS_BYTE_BITS  = 8;
   localparam int SMS_EDGE_BITS  = 4;
   localparam int SMS_HALF_BITS  = 7;
   // Core edges from an SCK decision to its MISO level in the second sync flop
   localparam int SMS_MISO_LAT   = 3;

   // Half periods of SCK in core clocks for each rate code
   localparam logic [6:0] SMS_HALF_N0 = 7'h02;
   localparam logic [6:0] SMS_HALF_N1 = 7'h08;
   localparam logic [6:0] SMS_HALF_N2 = 7'h20;
   localparam logic [6:0] SMS_HALF_N3 = 7'h40;
   localparam logic [6:0] SMS_HALF_D0 = 7'h01;
   localparam logic [6:0] SMS_HALF_D1 = 7'h04;
   localparam logic [6:0] SMS_HALF_D2 = 7'h10;
   localparam logic [6:0] SMS_HALF_D3 = 7'h20;
   localparam logic [6:0] SMS_HALF_ONE = 7'h01;

   localparam logic [3:0] SMS_LAST_EDGE = 4'hf;
   localparam logic [3:0] SMS_EDGE_ZERO = 4'h0;
   localparam logic [3:0] SMS_EDGE_ONE  = 4'h1;
   localparam logic [7:0] SMS_BYTE_ZERO = 8'h00;

   typedef enum logic {SMS_IDLE, SMS_RUN} sms_state_t;

endpackage : sms_pkg

/* File: tb/sms_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module sms_sva (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       ss_in,
   input wire logic       interface_enable,
   input wire logic       transfer_irq_enable,
   input wire logic       clock_idle_level,
   input wire logic       data_wr,
   input wire logic       data_rd,
   input wire logic       irq_ack,
   input wire logic [7:0] rx_data,
   input wire logic       master_select,
   input wire logic       transfer_complete_flag,
   input wire logic       write_collision_flag,
   input wire logic       irq,
   input wire logic       mosi_oe,
   input wire logic       miso_oe,
   input wire logic       sck_oe,
   input wire logic       sck_out,
   input wire logic       ss_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Four cycles covers the select synchroniser plus the output register
   sequence s_unsel;
      (interface_enable && !master_select && ss_in) [*4];
   endsequence
   sequence s_done;
      $rose(transfer_complete_flag);
   endsequence
   a_irq_on_flag: assert property (s_done ##0 transfer_irq_enable |=> irq)
      else $error("irq missing after flag");
   a_irq_masked: assert property (!transfer_irq_enable |=> !irq)
      else $error("irq while disabled");
   a_slave_unsel_quiet: assert property (s_unsel |-> !miso_oe)
      else $error("miso driven while deselected");
   a_master_miso_in: assert property ((interface_enable && master_select) [*2] |-> !miso_oe)
      else $error("miso driven in master mode");
   a_slave_pins_in: assert property ((interface_enable && !master_select) [*2]
      |-> !mosi_oe && !sck_oe && !ss_oe)
      else $error("slave drives an input pin");
   a_sck_idle_end: assert property (s_done ##0 master_select |-> sck_out == clock_idle_level)
      else $error("sck not idle at end");
   a_write_collision_flag_cause: assert property ($rose(write_collision_flag) |-> $past(data_wr))
      else $error("collision flag without write");
   a_rx_on_done: assert property (!$stable(rx_data) |-> transfer_complete_flag)
      else $error("rx data changed without flag");
   a_flag_sticky: assert property (transfer_complete_flag && !irq_ack && !data_rd && !data_wr
      |=> transfer_complete_flag)
      else $error("flag dropped without clear");
endmodule : sms_sva
bind sms_spi sms_sva i_sva (.*);
`default_nettype wire

/* File: tb/sms_peer.sv */
`timescale 1ns/100ps
`default_nettype none
module sms_peer (
   input  wire logic clk48,
   input  wire logic sck_in,
   input  wire logic mosi_in,
   input  wire logic miso_in,
   input  wire logic ss_in,
   output var  logic p_sck,
   output var  logic p_mosi,
   output var  logic p_miso,
   output var  logic p_ss
);
   logic [7:0] tx;
   logic [7:0] rx;
   logic       lsb;
   logic       busy;
   int         n;
   initial begin
      {p_sck, p_mosi, p_miso, busy, lsb, tx, rx} = '0;
      p_ss = 1'b1;
      n = 0;
   end
   // Released lines keep moving so a stale level never reads as data
   always @(posedge clk48) begin
      if (!busy) p_mosi <= ~p_mosi;
      if (ss_in) p_miso <= ~p_miso;
   end
   always @(negedge ss_in) begin
      if (!busy) p_miso = tx[lsb ? 0 : 7];
   end
   always @(posedge sck_in) begin
      if (!ss_in && !busy) begin
         rx = lsb ? {mosi_in, rx[7:1]} : {rx[6:0], mosi_in};
         n++;
      end
   end
   always @(negedge sck_in) begin
      if (!ss_in && !busy && n < 8) p_miso = tx[lsb ? n : 7 - n];
   end
   task automatic load(input logic [7:0] d, input logic l);
      tx = d;
      lsb = l;
      n = 0;
      p_miso = d[l ? 0 : 7];
   endtask : load
   task automatic sel(input logic v);
      p_ss = v;
   endtask : sel
   // Five link cycles per phase keep each SCK level over two core cycles
   task automatic frame(input logic [7:0] d, input logic l, input int nb);
      busy = 1'b1;
      @(posedge clk48);
      p_ss = 1'b0;
      repeat (10) @(posedge clk48);
      for (int i = 0; i < nb; i++) begin
         p_mosi = d[l ? i : 7 - i];
         repeat (5) @(posedge clk48);
         p_sck = 1'b1;
         rx = l ? {miso_in, rx[7:1]} : {rx[6:0], miso_in};
         repeat (5) @(posedge clk48);
         p_sck = 1'b0;
      end
      repeat (5) @(posedge clk48);
      p_ss = 1'b1;
      busy = 1'b0;
   endtask : frame
endmodule : sms_peer
`default_nettype wire

/* File: tb/sms_spi_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sms_spi_tb;
   logic       ref_clk, clk48, resetn, interface_enable, transfer_irq_enable;
   logic       bit_order_select, clock_idle_level, clock_sample_phase, ctrl_master_select;
   logic       rate_select_hi, rate_select_lo, double_speed, ss_drive_level;
   logic       mosi_dir, miso_dir, sck_dir, ss_dir;
   logic       ctrl_wr, irq_ack, status_rd, data_rd, data_wr;
   logic [7:0] data_wdata, rx_data, b, rb;
   logic       master_select, transfer_complete_flag, write_collision_flag, irq;
   logic       mosi_out, mosi_oe, miso_out, miso_oe, sck_out, sck_oe, ss_out, ss_oe;
   logic       p_sck, p_mosi, p_miso, p_ss;
   int         mismatches, comparisons, nh, k;
   int         hv [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
   wire logic  sck_in  = sck_oe ? sck_out : p_sck;
   wire logic  mosi_in = mosi_oe ? mosi_out : p_mosi;
   wire logic  miso_in = miso_oe ? miso_out : p_miso;
   wire logic  ss_in   = ss_oe ? ss_out : p_ss;
   sms_spi i_dut (.*);
   sms_peer i_peer (.*);
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Fractional offset keeps link edges off core edges
   initial begin
      clk48 = 1'b0;
      #7.3;
      forever #24 clk48 = ~clk48;
   end
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic strobe(input logic [4:0] s, input logic [7:0] d);
      @(posedge ref_clk);
      {ctrl_wr, irq_ack, status_rd, data_rd, data_wr} <= s;
      data_wdata <= d;
      @(posedge ref_clk);
      {ctrl_wr, irq_ack, status_rd, data_rd, data_wr} <= 5'h00;
   endtask : strobe
   task automatic wait_flag();
      nh = 0;
      for (int i = 0; i < 3000 && transfer_complete_flag !== 1'b1; i++) begin
         @(negedge ref_clk);
         nh += int'(sck_out === 1'b1);
      end
   endtask : wait_flag
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      #1_000_000;
      mismatches++;
      finish_test();
   end
   initial begin
      {resetn, interface_enable, transfer_irq_enable, bit_order_select, clock_idle_level} = '0;
      {clock_sample_phase, ctrl_master_select, rate_select_hi, rate_select_lo} = '0;
      {double_speed, mosi_dir, miso_dir, sck_dir, ss_dir, data_wdata} = '0;
      {ctrl_wr, irq_ack, status_rd, data_rd, data_wr} = '0;
      {mismatches, comparisons} = '0;
      ss_drive_level = 1'b1;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      interface_enable <= 1'b1;
      transfer_irq_enable <= 1'b1;
      {mosi_dir, sck_dir, ss_dir, ctrl_master_select} <= 4'hf;
      repeat (3) @(posedge ref_clk);
      strobe(5'h10, 8'h00);
      ss_drive_level <= 1'b0;
      for (k = 0; k < 8; k++) begin
         @(posedge ref_clk);
         {double_speed, rate_select_hi, rate_select_lo} <= k[2:0];
         bit_order_select <= k[0];
         b = 8'(k * 29) ^ 8'h5b;
         rb = ~b;
         i_peer.load(rb, k[0]);
         strobe(5'h01, b);
         if (k == 3) strobe(5'h01, 8'h00);
         wait_flag();
         repeat (2) @(negedge ref_clk);
         check("sck_high", 16'(8 * hv[k]), 16'(nh));
         check("peer_rx", 16'(b), 16'(i_peer.rx));
         check("rx_data", 16'(rb), 16'(rx_data));
         check("irq", 16'h0001, 16'(irq));
         check("write_collision_flag", 16'(k == 3), 16'(write_collision_flag));
         check("ss_out", 16'h0000, 16'(ss_out));
         strobe(5'h04, 8'h00);
         strobe(5'h02, 8'h00);
         repeat (2) @(negedge ref_clk);
         check("flag", 16'h0000, 16'(transfer_complete_flag));
      end
      // Idle high, trailing-edge sampling; the peer loads after SCK settles high
      @(posedge ref_clk);
      {clock_idle_level, clock_sample_phase, bit_order_select} <= 3'h6;
      repeat (4) @(posedge ref_clk);
      i_peer.load(8'ha5, 1'b0);
      strobe(5'h01, 8'h3c);
      wait_flag();
      repeat (2) @(negedge ref_clk);
      check("peer_rx", 16'h003c, 16'(i_peer.rx));
      check("rx_data", 16'h00a5, 16'(rx_data));
      check("sck_idle", 16'h0001, 16'(sck_out));
      strobe(5'h04, 8'h00);
      strobe(5'h02, 8'h00);
      {clock_idle_level, clock_sample_phase} <= 2'h0;
      $display("master rates done");
      @(posedge ref_clk);
      ss_dir <= 1'b0;
      i_peer.sel(1'b0);
      repeat (6) @(negedge ref_clk);
      check("master", 16'h0000, 16'(master_select));
      check("flag", 16'h0001, 16'(transfer_complete_flag));
      i_peer.sel(1'b1);
      strobe(5'h08, 8'h00);
      repeat (2) @(negedge ref_clk);
      check("flag", 16'h0000, 16'(transfer_complete_flag));
      $display("mode fault done");
      @(posedge ref_clk);
      miso_dir <= 1'b1;
      strobe(5'h01, 8'h96);
      repeat (4) @(negedge ref_clk);
      check("miso_oe", 16'h0000, 16'(miso_oe));
      i_peer.frame(8'hff, 1'b0, 4);
      repeat (8) @(negedge ref_clk);
      check("flag", 16'h0000, 16'(transfer_complete_flag));
      i_peer.frame(8'h5a, 1'b0, 8);
      repeat (8) @(negedge ref_clk);
      check("rx_data", 16'h005a, 16'(rx_data));
      check("flag", 16'h0001, 16'(transfer_complete_flag));
      @(posedge ref_clk);
      bit_order_select <= 1'b1;
      strobe(5'h01, 8'he7);
      i_peer.frame(8'hc3, 1'b1, 8);
      repeat (8) @(negedge ref_clk);
      check("rx_data", 16'h00c3, 16'(rx_data));
      check("peer_rx", 16'h00e7, 16'(i_peer.rx));
      $display("slave done");
      finish_test();
   end
endmodule : sms_spi_tb
`default_nettype wire
